// ### include/msc_pkg.sv
// Package of constants and types for the module sideband control block
package msc_pkg;

   // ------------------------------------------------------------------
   // Clock
   // ------------------------------------------------------------------
   localparam int CLK_FREQ_HZ   = 10_000_000;
   localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   // Least reset pulse, rounded up to whole cycles
   localparam int RESET_MIN_NS  = 10_000;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CNT_W     = 8;
   localparam logic [RST_CNT_W-1:0] RESET_MIN_CNT = RST_CNT_W'(RESET_MIN_CYC);

   // Longest power-on initialisation, rounded down to whole cycles
   localparam int INIT_TIME_MS  = 2000;
   localparam int INIT_CYC      = INIT_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int INIT_CNT_W    = 25;

   // ------------------------------------------------------------------
   // Reset values of pins and synchronisers
   // ------------------------------------------------------------------
   localparam logic PIN_IDLE    = 1'h1;
   localparam logic PULL_LOW    = 1'h0;

   // ------------------------------------------------------------------
   // States
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_HOLD  = 3'h1,
      ST_INIT  = 3'h2,
      ST_READY = 3'h4
   } msc_state_t;

endpackage

// ### include/msc_rst_if.sv
// Interface carrying the qualified module reset from the filter to the core
`timescale 1ns/1ps
interface msc_rst_if;
   logic hold;
   modport filt (output hold);
   modport core (input hold);
endinterface

// ### src/msc_reset_filter.sv
// Reset pin synchroniser and minimum pulse filter
`timescale 1ns/1ps
module msc_reset_filter
   import msc_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_n_i,
   // Pin
   input  wire logic module_reset_n_i,
   // Qualified reset
   msc_rst_if.filt   rst
);
   import msc_pkg::*;

   typedef struct packed {
      logic                 s1;
      logic                 s2;
      logic [RST_CNT_W-1:0] cnt;
      logic                 hold;
   } msc_rf_t;

   msc_rf_t q;
   msc_rf_t d;

   always_comb begin
      d    = q;
      d.s1 = module_reset_n_i;
      d.s2 = q.s1;
      // Glitches shorter than the least pulse never reach the core
      if (q.s2) begin
         d.cnt  = '0;
         d.hold = 1'h0;
      end else if (q.cnt == RESET_MIN_CNT) begin
         d.hold = 1'h1;
      end else begin
         d.cnt  = q.cnt + RST_CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         q <= '{s1: PIN_IDLE, s2: PIN_IDLE, cnt: '0, hold: 1'h0};
      end else begin
         q <= d;
      end
   end

   assign rst.hold = q.hold;

endmodule

// ### src/msc_sideband.sv
// Sideband control of a pluggable transceiver module: select, reset, power, attention
`timescale 1ns/1ps

// How it works
// - The two-wire target sees bus activity and may drive data only while module select is low.
// - A qualified reset pulse holds the module in reset and restores every setting to default.
// - Reset completion asserts attention and clears the data-not-ready flag.
// - After power-up the module completes its own reset without a reset pulse.
// - The low power request input caps the module power.
// - Attention is driven low on a fault or critical status event once the module is ready; faults during init or reset hold are ignored.
// - Attention is open drain: it only pulls low, the host pull-up makes the high.
// - Module present is tied low whenever the module is inserted.
// - The memory map is reached only through the two-wire lines, served as a target.
module msc_sideband
   import msc_pkg::*;
#(
   parameter int INIT_CYCLES = msc_pkg::INIT_CYC
)
(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_n_i,
   // Host control pins
   input  wire logic module_select_n_i,
   input  wire logic module_reset_n_i,
   input  wire logic low_power_request_i,
   // Two-wire pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_o,
   // Attention and presence pins
   output logic      attention_n_o,
   output logic      attention_oe_o,
   output logic      module_present_n_o,
   output logic      module_present_oe_o,
   // Two-wire target core side
   input  wire logic target_sda_drive_i,
   output logic      twi_scl_o,
   output logic      twi_sda_o,
   output logic      twi_scl_rise_o,
   output logic      twi_scl_fall_o,
   // Memory map side
   input  wire logic fault_event_i,
   input  wire logic flag_clear_i,
   output logic      data_not_ready_o,
   output logic      settings_default_o,
   output logic      low_power_o
);
   import msc_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   localparam logic [INIT_CNT_W-1:0] INIT_LAST = INIT_CNT_W'(INIT_CYCLES - 1);

   typedef struct packed {
      logic                  sel_s1;
      logic                  sel_s2;
      logic                  lp_s1;
      logic                  lp_s2;
      logic                  scl_s1;
      logic                  scl_s2;
      logic                  scl_s3;
      logic                  sda_s1;
      logic                  sda_s2;
      msc_state_t            state;
      logic [INIT_CNT_W-1:0] cnt;
      logic                  pend;
      logic                  dnr;
      logic                  dflt;
      logic                  lp;
      logic                  sda_oe;
      logic                  pull;
      logic                  pres_oe;
      logic                  t_scl;
      logic                  t_sda;
      logic                  t_rise;
      logic                  t_fall;
   } msc_core_t;

   // Power-up state: select and two-wire synchronisers sit at the idle pin level so no false edge follows reset; low power ones start at 0
   localparam msc_core_t CORE_RST = '{
      sel_s1:  PIN_IDLE,
      sel_s2:  PIN_IDLE,
      lp_s1:   1'h0,
      lp_s2:   1'h0,
      scl_s1:  PIN_IDLE,
      scl_s2:  PIN_IDLE,
      scl_s3:  PIN_IDLE,
      sda_s1:  PIN_IDLE,
      sda_s2:  PIN_IDLE,
      state:   ST_INIT,
      cnt:     '0,
      pend:    1'h0,
      dnr:     1'h1,
      dflt:    1'h1,
      lp:      1'h1,
      sda_oe:  1'h0,
      pull:    PULL_LOW,
      pres_oe: 1'h1,
      t_scl:   PIN_IDLE,
      t_sda:   PIN_IDLE,
      t_rise:  1'h0,
      t_fall:  1'h0
   };

   msc_core_t q;
   msc_core_t d;
   logic      set_att;
   logic      sel;

   msc_rst_if rst_if ();

   msc_reset_filter u_reset_filter (
      .sys_clk_i        (sys_clk_i),
      .reset_n_i        (reset_n_i),
      .module_reset_n_i (module_reset_n_i),
      .rst              (rst_if.filt)
   );

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   // One-cycle pulse on a rise of the synced clock pin; swapped arguments give the fall
   function automatic logic edge_seen(input logic now_v, input logic was_v);
      return now_v && !was_v;
   endfunction

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      d        = q;
      set_att  = 1'h0;
      d.sel_s1 = module_select_n_i;
      d.sel_s2 = q.sel_s1;
      d.lp_s1  = low_power_request_i;
      d.lp_s2  = q.lp_s1;
      d.scl_s1 = scl_i;
      d.scl_s2 = q.scl_s1;
      d.scl_s3 = q.scl_s2;
      d.sda_s1 = sda_i;
      d.sda_s2 = q.sda_s1;
      sel      = !q.sel_s2;

      // Deselected: the target core sees an idle bus and never drives
      d.t_scl  = sel ? q.scl_s2 : PIN_IDLE;
      d.t_sda  = sel ? q.sda_s2 : PIN_IDLE;
      d.t_rise = sel && edge_seen(q.scl_s2, q.scl_s3);
      d.t_fall = sel && edge_seen(q.scl_s3, q.scl_s2);
      d.sda_oe = sel && target_sda_drive_i && (q.state == ST_READY);

      case (q.state)
         ST_HOLD: begin
            d.cnt = '0;
            if (!rst_if.hold) begin
               d.state = ST_INIT;
            end
         end
         ST_INIT: begin
            if (q.cnt == INIT_LAST) begin
               d.state = ST_READY;
               d.dnr   = 1'h0;
               set_att = 1'h1;
            end else begin
               d.cnt = q.cnt + INIT_CNT_W'(1);
            end
         end
         ST_READY: begin
            set_att = fault_event_i;
         end
         default: begin
            d.state = ST_HOLD;
         end
      endcase

      // A new event in the clearing cycle wins over the clear
      d.pend = set_att || (q.pend && !flag_clear_i);

      if (rst_if.hold) begin
         d.state = ST_HOLD;
         d.cnt   = '0;
         d.pend  = 1'h0;
         d.dnr   = 1'h1;
         d.sda_oe = 1'h0;
      end
      d.dflt = rst_if.hold;

      // Full power only once up and not limited by the host
      d.lp = q.lp_s2 || (d.state != ST_READY);
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         q <= CORE_RST;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Open-drain pins only ever pull low; the enable carries the level
   assign sda_o               = q.pull;
   assign sda_oe_o            = q.sda_oe;
   assign attention_n_o       = q.pull;
   assign attention_oe_o      = q.pend;
   assign module_present_n_o  = q.pull;
   assign module_present_oe_o = q.pres_oe;
   assign twi_scl_o           = q.t_scl;
   assign twi_sda_o           = q.t_sda;
   assign twi_scl_rise_o      = q.t_rise;
   assign twi_scl_fall_o      = q.t_fall;
   assign data_not_ready_o    = q.dnr;
   assign settings_default_o  = q.dflt;
   assign low_power_o         = q.lp;

endmodule

// ### test/module_sideband_control_tb.sv
// Testbench of the module sideband control block
`timescale 1ns/1ps
module module_sideband_control_tb;
   import msc_pkg::*;
   localparam int INIT_N = 50;
   logic sys_clk_i, reset_n_i, module_select_n_i, module_reset_n_i, low_power_request_i;
   logic scl_i, sda_i, sda_o, sda_oe_o, attention_n_o, attention_oe_o, module_present_n_o;
   logic module_present_oe_o, target_sda_drive_i, twi_scl_o, twi_sda_o, twi_scl_rise_o;
   logic twi_scl_fall_o, fault_event_i, flag_clear_i, data_not_ready_o;
   logic settings_default_o, low_power_o, att_line;
   int   error_cnt = 0, samples_checked = 0, rise_cnt = 0, fall_cnt = 0;
   assign att_line = !attention_oe_o;
   msc_host_model host (.sys_clk_i(sys_clk_i), .sda_oe_i(sda_oe_o),
      .select_n_o(module_select_n_i), .reset_n_o(module_reset_n_i),
      .low_power_o(low_power_request_i), .scl_o(scl_i), .sda_line_o(sda_i));
   msc_sideband #(.INIT_CYCLES(INIT_N)) uut (.*);
   initial begin
      sys_clk_i = 1'h0;
      forever #50 sys_clk_i = !sys_clk_i;
   end
   always @(posedge sys_clk_i) if (twi_scl_rise_o === 1'h1) rise_cnt++;
   always @(posedge sys_clk_i) if (twi_scl_fall_o === 1'h1) fall_cnt++;
   task automatic chk(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // Bounded wait, so a module that never completes shows as a mismatch
   task automatic wait_ready;
      for (int i = 0; i < 200 && data_not_ready_o !== 1'h0; i++) tick(1);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #500000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      reset_n_i = 1'h0; target_sda_drive_i = 1'h0; fault_event_i = 1'h0; flag_clear_i = 1'h0;
      tick(4);
      reset_n_i = 1'h1;
      chk(module_present_oe_o, 1'h1);
      chk(att_line, 1'h1);
      tick(INIT_N - 6);
      chk(data_not_ready_o, 1'h1);
      wait_ready();
      chk(att_line, 1'h0);
      chk(low_power_o, 1'h1);
      $display("test power_up done");
      flag_clear_i = 1'h1;
      tick(1);
      flag_clear_i = 1'h0;
      chk(att_line, 1'h1);
      fault_event_i = 1'h1;
      tick(1);
      fault_event_i = 1'h0;
      tick(20);
      chk(att_line, 1'h0);
      fault_event_i = 1'h1;
      flag_clear_i = 1'h1;
      tick(1);
      fault_event_i = 1'h0;
      chk(att_line, 1'h0);
      tick(1);
      flag_clear_i = 1'h0;
      chk(att_line, 1'h1);
      host.low_power_o = 1'h0;
      tick(6);
      chk(low_power_o, 1'h0);
      host.low_power_o = 1'h1;
      tick(6);
      chk(low_power_o, 1'h1);
      $display("test attention_power done");
      target_sda_drive_i = 1'h1;
      rise_cnt = 0;
      fall_cnt = 0;
      host.frame(1'h0, 8, 4);
      chk(rise_cnt == 0, 1'h1);
      chk(fall_cnt == 0, 1'h1);
      fork
         host.frame(1'h1, 9, 8);
         begin
            tick(20);
            chk(sda_i, 1'h0);
            chk(twi_sda_o, 1'h0);
         end
      join
      chk(rise_cnt == 9, 1'h1);
      chk(fall_cnt == 9, 1'h1);
      tick(5);
      chk(sda_i, 1'h1);
      target_sda_drive_i = 1'h0;
      $display("test serial_select done");
      host.reset_n_o = 1'h0;
      tick(50);
      host.reset_n_o = 1'h1;
      tick(5);
      chk(settings_default_o, 1'h0);
      host.reset_n_o = 1'h0;
      tick(110);
      chk(settings_default_o, 1'h1);
      chk(att_line, 1'h1);
      fault_event_i = 1'h1;
      tick(1);
      fault_event_i = 1'h0;
      chk(att_line, 1'h1);
      host.reset_n_o = 1'h1;
      tick(5);
      wait_ready();
      chk(att_line, 1'h0);
      $display("test reset_pin done");
      wrap_up();
   end
endmodule

// ### test/msc_host_model.sv
// Host board model: pull-ups, control pins and framed serial clock
`timescale 1ns/1ps
module msc_host_model (
   input  wire logic sys_clk_i,
   input  wire logic sda_oe_i,
   output logic      select_n_o, reset_n_o, low_power_o, scl_o,
   output wire logic sda_line_o);
   // Pull-up: line is high unless the module pulls it down
   assign sda_line_o = !sda_oe_i;
   initial begin
      select_n_o = 1'h1; reset_n_o = 1'h1; low_power_o = 1'h1; scl_o = 1'h1;
   end
   // Clock stands high outside frames; one select line per module
   task automatic frame(input logic sel, input int bits, input int half);
      @(negedge sys_clk_i) select_n_o = !sel;
      repeat (4) @(negedge sys_clk_i);
      for (int i = 0; i < 2 * bits; i++) begin
         repeat (half) @(negedge sys_clk_i);
         scl_o = !scl_o;
      end
      repeat (4) @(negedge sys_clk_i);
      select_n_o = 1'h1;
   endtask
endmodule

// ### test/msc_properties.sv
// Checker of the sideband pin rules
`timescale 1ns/1ps
module msc_properties #(parameter int INIT_CYCLES = 50) (
   input wire logic sys_clk_i, reset_n_i, module_select_n_i, module_reset_n_i,
   input wire logic low_power_request_i, scl_i, sda_i, sda_o, sda_oe_o,
   input wire logic attention_n_o, attention_oe_o, module_present_n_o,
   input wire logic module_present_oe_o, target_sda_drive_i, twi_scl_o, twi_sda_o,
   input wire logic twi_scl_rise_o, twi_scl_fall_o, fault_event_i, flag_clear_i,
   input wire logic data_not_ready_o, settings_default_o, low_power_o);
   localparam int LO = INIT_CYCLES - 10;
   localparam int HI = INIT_CYCLES - 4;
   logic [7:0] low_q;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Saturates so that a long hold never wraps back to a short count
   always_ff @(posedge sys_clk_i)
      low_q <= (!reset_n_i || module_reset_n_i) ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
   sequence s_desel; module_select_n_i [*5]; endsequence
   sequence s_init; data_not_ready_o [*8] ##[LO:HI] $fell(data_not_ready_o); endsequence
   chk_sel_gate: assert property (s_desel |-> !sda_oe_o && twi_scl_o && twi_sda_o
      && !twi_scl_rise_o && !twi_scl_fall_o) else $error("bus active while deselected");
   chk_pins_pull_low: assert property (!attention_n_o && !sda_o && !module_present_n_o
      && module_present_oe_o) else $error("pin drives high or present released");
   chk_low_power: assert property (low_power_request_i [*4] |=> low_power_o)
      else $error("power not capped");
   chk_reset_hold: assert property (low_q > 8'h6a |-> settings_default_o
      && data_not_ready_o && !attention_oe_o) else $error("long reset pulse ignored");
   chk_short_pulse: assert property (low_q < 8'h5a && !data_not_ready_o
      |=> !settings_default_o) else $error("short reset pulse taken");
   chk_ready_attn: assert property ($fell(data_not_ready_o) |-> attention_oe_o)
      else $error("ready without attention");
   chk_init_time: assert property ($fell(settings_default_o) |-> s_init)
      else $error("init length wrong");
   chk_fault_attn: assert property (fault_event_i && !data_not_ready_o && module_reset_n_i
      |=> attention_oe_o) else $error("fault not flagged");
   chk_attn_clear: assert property (flag_clear_i && !fault_event_i && !data_not_ready_o
      |=> !attention_oe_o) else $error("attention not cleared");
   chk_attn_sticky: assert property (module_reset_n_i [*4] ##0 (attention_oe_o
      && !flag_clear_i) |=> attention_oe_o) else $error("attention dropped");
endmodule
bind msc_sideband msc_properties #(.INIT_CYCLES(INIT_CYCLES)) chk (.*);
